// [wdr_map.svh]
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDR_MAP_SVH
`define WDR_MAP_SVH

// register byte addresses on the 16-bit register port
`define WDR_OFF_SERVICE 16'hFFFF
`define WDR_OFF_CAUSE 16'h0001
`define WDR_OFF_STATUS 16'h0002
`define WDR_OFF_OPTION 16'h001F

// option word one fields
`define WDR_OPT_DISABLE_BIT 0
`define WDR_OPT_STOP_EN_BIT 1
`define WDR_OPT_RATE_BIT 2
`define WDR_OPT_RESET 8'h00

// reset cause fields
`define WDR_CAUSE_WDOG_BIT 1
`define WDR_CAUSE_ILLOP_BIT 3
`define WDR_CAUSE_RESET 8'h00

// timing in internal oscillator cycles
`define WDR_LONG_TIMEOUT 18'h3FFF0
`define WDR_SHORT_TIMEOUT 18'h01FF0
`define WDR_POR_TICKS 13'h1000
`define WDR_PULSE_TICKS 6'h20
`define WDR_PRESC_SVC_LSB 4

`endif

// [wdr_pkg.sv]
// types shared by the watchdog design
package wdr_pkg;

  // one register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdr_bus_req_s;

  // option word one contents
  typedef struct packed {
    logic rate_sel;
    logic stop_en;
    logic wd_disable;
  } wdr_opt_s;

  // test-voltage and mode levels that can suspend the watchdog
  typedef struct packed {
    logic monitor_mode;
    logic break_active;
    logic irq_hv;
    logic rst_hv;
  } wdr_mode_s;

  // reset pulse sequencer
  typedef enum logic [1:0] {
    WDR_RS_IDLE = 2'b01,
    WDR_RS_PULSE = 2'b10
  } wdr_rst_e;

endpackage

// [wdr_top.sv]
// watchdog counter with prescaler, service port, reset pulse and reset cause
`timescale 1ns/1ns
`include "wdr_map.svh"

// Behaviour
// - 6-bit counter fed by 12-bit prescaler carry
// - unserviced overflow raises system reset
// - rate bit picks short or long timeout
// - service write clears counter, prescaler bits 11..4
// - reset holds pin low 32 cycles, flags cause
// - service read returns vector low byte only
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - disable bit level turns watchdog off
// - watchdog never requests a processor interrupt
// - monitor mode with test voltage disables
// - counting continues during wait mode
// - stop gates clock and clears prescaler
// - stop disabled: stop gives illegal-opcode reset
// - break with test voltage on reset disables
// - counters clocked by internal oscillator clock
module wdr_top
  import wdr_pkg::*;
#(
  parameter logic [17:0] LONG_TIMEOUT = `WDR_LONG_TIMEOUT,
  parameter logic [17:0] SHORT_TIMEOUT = `WDR_SHORT_TIMEOUT
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register port
  input wire wdr_bus_req_s bus_req_in,
  output logic [7:0] reg_rdata_out,
  // oscillator and system events
  input wire logic internal_osc_clock_in,
  input wire logic int_reset_in,
  input wire logic vec_fetch_in,
  input wire logic [7:0] reset_vector_lo_in,
  input wire logic stop_mode_in,
  input wire logic stop_exec_in,
  // mode and test-voltage levels from pins
  input wire wdr_mode_s mode_pins_in,
  // open-drain reset pin and reset requests
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  output logic wdog_reset_out,
  output logic illop_reset_out
);

  // address match shared by read and write decode
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  wdr_mode_s mode_s1_r;
  wdr_mode_s mode_s2_r;
  logic raw_tick;
  logic tick;
  logic [11:0] presc_r;
  logic [5:0] cnt_r;
  logic [12:0] por_cnt_r;
  logic por_done_r;
  logic por_clear;
  wdr_opt_s opt_r;
  logic [7:0] cause_r;
  logic [7:0] rdata_r;
  wdr_rst_e rs_state_r;
  wdr_rst_e rs_state_nxt;
  logic [5:0] pulse_cnt_r;
  logic illop_r;
  logic wd_off;
  logic svc_wr;
  logic svc_rd;
  logic [17:0] limit;
  logic ovf_evt;
  logic pulse_done;
  logic [17:0] total;

  // oscillator and pin levels pass two flip-flops first
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      mode_s1_r <= '0;
      mode_s2_r <= '0;
    end else if (ce_in) begin
      osc_s1_r <= internal_osc_clock_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      mode_s1_r <= mode_pins_in;
      mode_s2_r <= mode_s1_r;
    end
  end

  // one tick per oscillator rising edge; stop gates it off
  assign raw_tick = ce_in & osc_s2_r & ~osc_s3_r;
  assign tick = raw_tick & ~stop_mode_in;

  // wait mode has no input: counting simply goes on

  // watchdog off by option bit, monitor or break test voltage
  always_comb begin
    wd_off = opt_r.wd_disable;
    if (mode_s2_r.monitor_mode && (mode_s2_r.irq_hv || mode_s2_r.rst_hv)) begin
      wd_off = 1'b1;
    end
    if (mode_s2_r.break_active && mode_s2_r.rst_hv) begin
      wd_off = 1'b1;
    end
  end

  // register port decode
  assign svc_wr = ce_in & bus_req_in.wr & hit(bus_req_in.addr, `WDR_OFF_SERVICE);
  assign svc_rd = ce_in & bus_req_in.rd & hit(bus_req_in.addr, `WDR_OFF_SERVICE);

  // timeout selection and overflow detection
  assign limit = opt_r.rate_sel ? SHORT_TIMEOUT : LONG_TIMEOUT;
  assign total = {cnt_r, presc_r};
  assign ovf_evt = tick & ~wd_off & ~svc_wr & ~int_reset_in
    & (rs_state_r == WDR_RS_IDLE) & (total == limit - 18'h00001);

  // power-up wait before the one-time prescaler clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      por_cnt_r <= 13'h0000;
      por_done_r <= 1'b0;
    end else if (ce_in && !por_done_r && raw_tick) begin
      por_cnt_r <= por_cnt_r + 13'h0001;
      if (por_cnt_r == `WDR_POR_TICKS - 13'h0001) begin
        por_done_r <= 1'b1;
      end
    end
  end
  assign por_clear = raw_tick & ~por_done_r & (por_cnt_r == `WDR_POR_TICKS - 13'h0001);

  // 12-bit prescaler owned by the system side
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc_r <= 12'h000;
    end else if (ce_in) begin
      if (int_reset_in || rs_state_r == WDR_RS_PULSE) begin
        presc_r <= 12'h000;
      end else if (stop_mode_in) begin
        presc_r <= 12'h000;
      end else if (vec_fetch_in) begin
        presc_r <= 12'h000;
      end else if (por_clear) begin
        presc_r <= 12'h000;
      end else if (svc_wr) begin
        presc_r <= {8'h00, presc_r[3:0]};
      end else if (tick) begin
        presc_r <= presc_r + 12'h001;
      end
    end
  end

  // 6-bit watchdog counter stepped by prescaler carry
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 6'h00;
    end else if (ce_in) begin
      if (int_reset_in || rs_state_r == WDR_RS_PULSE) begin
        cnt_r <= 6'h00;
      end else if (wd_off) begin
        cnt_r <= 6'h00;
      end else if (svc_wr) begin
        cnt_r <= 6'h00;
      end else if (tick && presc_r == 12'hFFF) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // reset pulse sequencer next state
  assign pulse_done = tick & (pulse_cnt_r == `WDR_PULSE_TICKS - 6'h01);
  always_comb begin
    rs_state_nxt = rs_state_r;
    case (rs_state_r)
      WDR_RS_IDLE: begin
        if (ovf_evt) begin
          rs_state_nxt = WDR_RS_PULSE;
        end
      end
      WDR_RS_PULSE: begin
        if (pulse_done) begin
          rs_state_nxt = WDR_RS_IDLE;
        end
      end
      default: begin
        rs_state_nxt = WDR_RS_IDLE;
      end
    endcase
  end

  // reset pulse state and its oscillator-cycle length
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rs_state_r <= WDR_RS_IDLE;
      pulse_cnt_r <= 6'h00;
    end else if (ce_in) begin
      rs_state_r <= rs_state_nxt;
      if (rs_state_r != WDR_RS_PULSE) begin
        pulse_cnt_r <= 6'h00;
      end else if (tick) begin
        pulse_cnt_r <= pulse_cnt_r + 6'h01;
      end
    end
  end

  // stop attempted while stop is disabled: illegal-opcode reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      illop_r <= 1'b0;
    end else if (ce_in) begin
      illop_r <= stop_exec_in & ~opt_r.stop_en;
    end
  end

  // option word one, written by software
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opt_r <= wdr_opt_s'(3'(`WDR_OPT_RESET));
    end else if (ce_in && bus_req_in.wr && hit(bus_req_in.addr, `WDR_OFF_OPTION)) begin
      opt_r.wd_disable <= bus_req_in.wdata[`WDR_OPT_DISABLE_BIT];
      opt_r.stop_en <= bus_req_in.wdata[`WDR_OPT_STOP_EN_BIT];
      opt_r.rate_sel <= bus_req_in.wdata[`WDR_OPT_RATE_BIT];
    end
  end

  // reset cause flags: cleared by a read, a new event wins
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cause_r <= `WDR_CAUSE_RESET;
    end else if (ce_in) begin
      if (bus_req_in.rd && hit(bus_req_in.addr, `WDR_OFF_CAUSE)) begin
        cause_r <= 8'h00;
      end
      if (ovf_evt) begin
        cause_r[`WDR_CAUSE_WDOG_BIT] <= 1'b1;
      end
      if (stop_exec_in && !opt_r.stop_en) begin
        cause_r[`WDR_CAUSE_ILLOP_BIT] <= 1'b1;
      end
    end
  end

  // read data, valid the cycle after the read strobe
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
    end else if (ce_in) begin
      if (svc_rd) begin
        rdata_r <= reset_vector_lo_in;
      end else if (bus_req_in.rd && hit(bus_req_in.addr, `WDR_OFF_CAUSE)) begin
        rdata_r <= cause_r;
      end else if (bus_req_in.rd && hit(bus_req_in.addr, `WDR_OFF_STATUS)) begin
        rdata_r <= {2'b00, cnt_r};
      end else if (bus_req_in.rd && hit(bus_req_in.addr, `WDR_OFF_OPTION)) begin
        rdata_r <= {5'b00000, opt_r.rate_sel, opt_r.stop_en, opt_r.wd_disable};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // outputs; no interrupt request exists here
  assign reg_rdata_out = rdata_r;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_out = rs_state_r[1];
  assign wdog_reset_out = rs_state_r[1];
  assign illop_reset_out = illop_r;

  // checks on the watchdog behaviour
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_pulse_start;
    (rs_state_r == WDR_RS_IDLE) ##1 (rs_state_r == WDR_RS_PULSE);
  endsequence

  sequence s_pulse_last;
    (rs_state_r == WDR_RS_PULSE) && pulse_done;
  endsequence

  a_service_clears: assert property (svc_wr |=> (cnt_r == 6'h00) && (presc_r[11:4] == 8'h00))
    else $error("service write did not clear counters");

  a_overflow_reset: assert property (ovf_evt |=> rst_pin_oe_out && wdog_reset_out)
    else $error("overflow did not start reset pulse");

  a_timeout_value: assert property (ovf_evt |-> total == limit - 18'h00001)
    else $error("overflow at wrong count");

  a_pulse_end: assert property (s_pulse_last ##0 ce_in |=> !rst_pin_oe_out)
    else $error("reset pulse did not end after 32 cycles");

  a_pulse_hold: assert property (s_pulse_start |-> pulse_cnt_r == 6'h00)
    else $error("reset pulse count not at zero on start");

  a_cause_flag: assert property (ovf_evt |=> cause_r[`WDR_CAUSE_WDOG_BIT])
    else $error("watchdog cause flag not set");

  a_read_vector: assert property (svc_rd |=> reg_rdata_out == $past(reset_vector_lo_in))
    else $error("service read not vector low byte");

  a_read_no_clear: assert property (svc_rd && !tick && !int_reset_in && !wd_off
    && !stop_mode_in && !vec_fetch_in && rs_state_r == WDR_RS_IDLE |=> $stable(cnt_r)
    && $stable(presc_r))
    else $error("service read changed counters");

  a_disable_holds: assert property (ce_in && wd_off |=> cnt_r == 6'h00 && !$rose(wdog_reset_out))
    else $error("disabled watchdog kept counting");

  a_stop_clears: assert property (ce_in && stop_mode_in |=> presc_r == 12'h000)
    else $error("stop did not clear prescaler");

  a_vec_fetch: assert property (ce_in && vec_fetch_in |=> presc_r == 12'h000)
    else $error("vector fetch did not clear prescaler");

  a_int_reset: assert property (ce_in && int_reset_in |=> presc_r == 12'h000 && cnt_r == 6'h00)
    else $error("internal reset did not clear counters");

  a_illegal_stop: assert property (ce_in && stop_exec_in && !opt_r.stop_en |=> illop_reset_out)
    else $error("disabled stop gave no illegal reset");

  a_por_clear: assert property (ce_in && por_clear |=> presc_r == 12'h000)
    else $error("power-up wait did not clear prescaler");

endmodule

// [wdr_osc_model.sv]
// free-running model of the slow internal oscillator
`timescale 1ns/1ns
module wdr_osc_model #(
  parameter int HALF_NS = 200
) (
  // oscillator level
  output logic osc_out
);
  // runs from power-up, phase unrelated to the system clock
  initial begin
    osc_out = 1'b0;
    #37;
    forever #(HALF_NS) osc_out = ~osc_out;
  end
endmodule

// [wdr_top_tb.sv]
// testbench for the watchdog timeouts, service port and reset pulse
`timescale 1ns/1ns
`include "wdr_map.svh"
module wdr_top_tb;
  import wdr_pkg::*;
  localparam logic [17:0] LT = 18'h00120;
  localparam logic [17:0] ST = 18'h00050;
  localparam int TK = 8; // system clocks per oscillator tick
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic irst = 1'b0;
  logic vfetch = 1'b0;
  logic stop = 1'b0;
  logic stop_x = 1'b0;
  logic osc;
  logic pin, pin_oe, wdog, illop;
  logic [7:0] rdata;
  wdr_bus_req_s req = '0;
  wdr_mode_s mode = '0;
  logic [7:0] opt_tab [4] = '{8'h05, 8'h04, 8'h04, 8'h04};
  logic [3:0] mode_tab [4] = '{4'h0, 4'hA, 4'h9, 4'h5};
  int bad_count = 0;
  int checks = 0;

  // design and oscillator
  wdr_top #(.LONG_TIMEOUT(LT), .SHORT_TIMEOUT(ST)) uut (
    .clk_sys_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .bus_req_in(req),
    .reg_rdata_out(rdata), .internal_osc_clock_in(osc), .int_reset_in(irst),
    .vec_fetch_in(vfetch), .reset_vector_lo_in(8'hA7), .stop_mode_in(stop),
    .stop_exec_in(stop_x), .mode_pins_in(mode), .rst_pin_out(pin),
    .rst_pin_oe_out(pin_oe), .wdog_reset_out(wdog), .illop_reset_out(illop));
  wdr_osc_model #(.HALF_NS(TK * 25)) osc_m (.osc_out(osc));

  // 20 MHz system clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) req <= {a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 chk(rdata, e);
  endtask

  // n cycles with no watchdog reset
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 if (wdog !== 1'b0) seen = 1'b1;
    end
    chk({7'h00, seen}, 8'h00);
  endtask

  // internal reset pulse restarts the count from zero
  task automatic fresh();
    @(posedge clk) irst <= 1'b1;
    @(posedge clk) irst <= 1'b0;
  endtask

  // timeout length in ticks, then pulse length and cause flag
  task automatic timeout(input int lim);
    int n;
    int p;
    n = 0;
    p = 0;
    while (wdog !== 1'b1 && n < lim * TK + 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n >= lim * TK - 16 && n <= lim * TK + 16), 8'h01);
    chk({6'h00, pin_oe, pin}, 8'h02);
    while (wdog === 1'b1 && p < 400) begin
      @(posedge clk);
      #1 p++;
    end
    chk(8'(p >= 32 * TK - 8 && p <= 32 * TK + 8), 8'h01);
    rd(`WDR_OFF_CAUSE, 8'h02);
    rd(`WDR_OFF_CAUSE, 8'h00);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`WDR_OFF_CAUSE, `WDR_CAUSE_RESET);
    rd(`WDR_OFF_OPTION, `WDR_OPT_RESET);
    rd(16'h0040, 8'h00);
    wr(`WDR_OFF_SERVICE, 8'h5A);
    rd(`WDR_OFF_SERVICE, 8'hA7);
    fresh();
    timeout(LT);
    wr(`WDR_OFF_OPTION, 8'h04);
    rd(`WDR_OFF_OPTION, 8'h04);
    fresh();
    timeout(ST);
    // regular servicing holds off the reset; wait mode has no input
    repeat (4) begin
      wr(`WDR_OFF_SERVICE, 8'hFF);
      quiet(ST * TK / 2);
    end
    // each disable source suppresses the reset
    for (int i = 0; i < 4; i++) begin
      wr(`WDR_OFF_OPTION, opt_tab[i]);
      mode <= mode_tab[i];
      fresh();
      quiet(ST * TK * 2);
    end
    wr(`WDR_OFF_OPTION, 8'h04);
    mode <= 4'h4; // break without test voltage still counts
    fresh();
    timeout(ST);
    mode <= 4'h0;
    // mid-count clears by internal reset and vector fetch
    fresh();
    quiet(ST * TK / 2);
    fresh();
    timeout(ST);
    quiet(ST * TK / 2);
    @(posedge clk) vfetch <= 1'b1;
    @(posedge clk) vfetch <= 1'b0;
    timeout(ST);
    // stop gates ticks and clears the prescaler
    quiet(ST * TK / 2);
    @(posedge clk) stop <= 1'b1;
    quiet(ST * TK * 2);
    @(posedge clk) stop <= 1'b0;
    timeout(ST);
    // stop instruction while stop is disabled
    @(posedge clk) stop_x <= 1'b1;
    @(posedge clk) stop_x <= 1'b0;
    #1 chk({7'h00, illop}, 8'h01);
    @(posedge clk);
    #1 chk({7'h00, illop}, 8'h00);
    rd(`WDR_OFF_CAUSE, 8'h08);
    wr(`WDR_OFF_OPTION, 8'h06);
    @(posedge clk) stop_x <= 1'b1;
    @(posedge clk) stop_x <= 1'b0;
    #1 chk({7'h00, illop}, 8'h00);
    // disabled run long enough to pass the power-up prescaler clear
    wr(`WDR_OFF_OPTION, 8'h05);
    quiet(18000);
    rd(`WDR_OFF_STATUS, 8'h00);
    conclude();
  end

  // hang guard
  initial begin
    #3000000;
    bad_count++;
    conclude();
  end
endmodule
